// file: shared/srx_pkg.sv
// constants and types for the serial receive datapath
// Notes on behaviour
// - static mode samples at a fixed configured phase, no adjustment
// - static mode captures on rising or falling edge per configuration
// - static mode: bit slip and deserializer run on the high-speed clock
// - dynamic mode picks the phase that best centres the data eye
// - dynamic mode writes the synchronizer with the selected-phase sample
// - dynamic mode reads the synchronizer on the high-speed clock
// - dynamic mode: bit slip and deserializer use the reading clock
// - soft recovery mode takes the local clock as pll reference
// - soft recovery mode keeps stepping phase to follow ppm offset
// - soft recovery mode: slip and deserializer on selected phase, no fifo
// - soft recovery mode forwards selected phase divided by factor
// - soft recovery output word is synchronous to recovered clock
// - pll parallel clock is still forwarded in soft recovery mode
// - parallel output is at most ten bits wide
// - static mode bypass delivers one bit single rate, two bits double rate
// - sampling clock runs at the bit rate, one period per bit
// - synchronizer is one bit by six deep, reset on first lock
// - each slip control rising edge below rollover adds one bit of delay, the rollover edge clears it
// - deserializer ratios are 4, 6, 7, 8 or 10
// - eight phases, 45 degrees apart
package srx_pkg;
  localparam int NUM_PHASES = 8;
  localparam logic [2:0] PHASE_HALF = 3'h4;
  localparam int WORD_W = 10;
  localparam int HIST_W = 11;
  localparam int FIFO_DEPTH = 6;
  localparam logic [2:0] FIFO_START = 3'h3;
  localparam logic [8:0] LOCK_COUNT = 9'h100;
  localparam logic [3:0] FACTOR_DEF = 4'hA;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_SLIP = 8'h08;
  localparam logic [7:0] ADDR_WORD = 8'h0C;
  localparam int CTRL_W = 19;
  localparam logic [18:0] CTRL_RST = 19'h55002;

  typedef enum logic [2:0]
  {
    MODE_STATIC_PHASE = 3'b001,
    MODE_DYNAMIC_PHASE_ALIGN = 3'b010,
    MODE_SOFT_CDR = 3'b100
  } srx_mode_type;

  typedef struct packed
  {
    logic [3:0] rollover;
    logic [3:0] factor;
    logic [2:0] phase;
    logic hold;
    logic ddr;
    logic bypass;
    logic edge_fall;
    logic [2:0] mode;
    logic enable;
  } srx_ctrl_type;

  typedef struct packed
  {
    logic valid;
    logic [9:0] data;
  } srx_word_type;
endpackage : srx_pkg

// file: src/srx_sync_fifo.sv
// one bit wide synchronizer fifo between selected phase and pll clock
`timescale 1ns/10ps
module srx_sync_fifo
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  input wire logic wr_en,
  input wire logic wr_bit,
  output logic rd_bit,
  output logic rd_ok
);
  logic mem [srx_pkg::FIFO_DEPTH];
  logic [2:0] wptr;
  logic [2:0] rptr;
  logic [2:0] count;
  logic full;
  logic do_wr;
  logic do_rd;

  assign full = (count == 3'(srx_pkg::FIFO_DEPTH));
  assign do_rd = rd_ok & (count != 3'h0);
  assign do_wr = wr_en & (~full | do_rd);

  // pointers and fill level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wptr <= 3'h0;
      rptr <= 3'h0;
      count <= 3'h0;
    end
    else if (clear)
    begin
      wptr <= 3'h0;
      rptr <= 3'h0;
      count <= 3'h0;
    end
    else
    begin
      if (do_wr)
        wptr <= (wptr == 3'(srx_pkg::FIFO_DEPTH - 1)) ? 3'h0 : wptr + 3'h1;
      if (do_rd)
        rptr <= (rptr == 3'(srx_pkg::FIFO_DEPTH - 1)) ? 3'h0 : rptr + 3'h1;
      count <= count + 3'(do_wr) - 3'(do_rd);
    end
  end

  // storage
  always_ff @(posedge pclk)
  begin
    if (do_wr)
      mem[wptr] <= wr_bit;
  end

  // reading starts half full, then runs every cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rd_ok <= 1'b0;
      rd_bit <= 1'b0;
    end
    else if (clear)
    begin
      rd_ok <= 1'b0;
      rd_bit <= 1'b0;
    end
    else
    begin
      if (count >= srx_pkg::FIFO_START)
        rd_ok <= 1'b1;
      if (do_rd)
        rd_bit <= mem[rptr];
    end
  end
endmodule : srx_sync_fifo

// file: src/srx_rx_datapath.sv
// receive datapath: phase alignment, synchronizer, slip, deserializer
`timescale 1ns/10ps
module srx_rx_datapath
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] phase_taps,
  output logic pll_ref_local,
  output srx_pkg::srx_word_type rx_out,
  output logic par_clk_pll,
  output logic par_clk_rec,
  output logic slip_max
);
  srx_pkg::srx_ctrl_type ctrl;
  srx_pkg::srx_ctrl_type run_cfg;
  srx_pkg::srx_mode_type mode;
  logic running;
  logic [2:0] phase;
  logic [8:0] stable_cnt;
  logic locked;
  logic lock_pulse;
  logic has_edge;
  logic [2:0] edge_at;
  logic [2:0] target;
  logic [2:0] diff;
  logic step_ok;
  logic slip_ctl;
  logic slip_prev;
  logic [3:0] slip_cnt;
  logic [10:0] hist;
  logic [3:0] bit_cnt;
  logic [9:0] shreg;
  logic [9:0] next_shreg;
  logic [9:0] word_mask;
  logic [3:0] eff_factor;
  logic [3:0] pll_cnt;
  logic [2:0] static_idx;
  logic src_bit;
  logic bit_ok;
  logic slip_bit;
  logic word_ok;
  logic fifo_bit;
  logic fifo_ok;
  logic fifo_clear;
  logic bypass_on;
  logic setup;
  logic wr_access;

  // first transition between neighbouring phase taps
  function automatic logic [2:0] first_edge(input logic [7:0] t);
    logic [2:0] pos;
    pos = 3'h0;
    for (int i = srx_pkg::NUM_PHASES - 2; i >= 0; i--)
    begin
      if (t[i] ^ t[i + 1])
        pos = 3'(i + 1);
    end
    return pos;
  endfunction : first_edge

  // mode code held in the configuration
  always_comb
  begin
    unique case (run_cfg.mode)
      srx_pkg::MODE_STATIC_PHASE: mode = srx_pkg::MODE_STATIC_PHASE;
      srx_pkg::MODE_DYNAMIC_PHASE_ALIGN:
        mode = srx_pkg::MODE_DYNAMIC_PHASE_ALIGN;
      srx_pkg::MODE_SOFT_CDR: mode = srx_pkg::MODE_SOFT_CDR;
      default: mode = srx_pkg::MODE_STATIC_PHASE;
    endcase
  end

  // supported ratios, anything else falls back to ten
  always_comb
  begin
    unique case (run_cfg.factor)
      4'h4, 4'h6, 4'h7, 4'h8, 4'hA: eff_factor = run_cfg.factor;
      default: eff_factor = srx_pkg::FACTOR_DEF;
    endcase
  end

  assign word_mask = ~(10'h3FF << eff_factor);
  assign bypass_on = run_cfg.bypass & (mode == srx_pkg::MODE_STATIC_PHASE);

  // configuration frozen while enabled
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_cfg <= srx_pkg::srx_ctrl_type'(srx_pkg::CTRL_RST);
      running <= 1'b0;
    end
    else
    begin
      if (!ctrl.enable)
        run_cfg <= ctrl;
      running <= ctrl.enable;
    end
  end

  assign pll_ref_local = running & (mode == srx_pkg::MODE_SOFT_CDR);

  // phase error from the tap transition
  assign has_edge = |(phase_taps[6:0] ^ phase_taps[7:1]);
  assign edge_at = first_edge(phase_taps);
  assign target = edge_at + srx_pkg::PHASE_HALF;
  assign diff = target - phase;
  assign step_ok = (mode == srx_pkg::MODE_SOFT_CDR) | ~run_cfg.hold | ~locked;
  assign lock_pulse = ~locked & (stable_cnt == srx_pkg::LOCK_COUNT);

  // phase alignment and lock tracking
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase <= 3'h0;
      stable_cnt <= 9'h000;
      locked <= 1'b0;
    end
    else if (!running || mode == srx_pkg::MODE_STATIC_PHASE)
    begin
      phase <= run_cfg.phase;
      stable_cnt <= 9'h000;
      locked <= 1'b0;
    end
    else
    begin
      if (has_edge && diff != 3'h0 && step_ok)
      begin
        if (diff[2])
          phase <= phase - 3'h1;
        else
          phase <= phase + 3'h1;
      end
      if (has_edge && diff != 3'h0)
        stable_cnt <= 9'h000;
      else if (stable_cnt != srx_pkg::LOCK_COUNT)
        stable_cnt <= stable_cnt + 9'h001;
      if (lock_pulse)
        locked <= 1'b1;
    end
  end

  // static phase, shifted half a period for the falling edge
  always_comb
  begin
    static_idx = run_cfg.phase;
    if (run_cfg.edge_fall)
      static_idx = run_cfg.phase + srx_pkg::PHASE_HALF;
  end

  assign fifo_clear = ~running | lock_pulse;

  srx_sync_fifo u_sync
  (
    .pclk(pclk),
    .presetn(presetn),
    .clear(fifo_clear),
    .wr_en(locked & (mode == srx_pkg::MODE_DYNAMIC_PHASE_ALIGN)),
    .wr_bit(phase_taps[phase]),
    .rd_bit(fifo_bit),
    .rd_ok(fifo_ok)
  );

  // bit source chosen by mode, one bit per clock
  always_comb
  begin
    src_bit = 1'b0;
    bit_ok = 1'b0;
    unique case (mode)
      srx_pkg::MODE_STATIC_PHASE:
      begin
        src_bit = phase_taps[static_idx];
        bit_ok = running & ~bypass_on;
      end
      srx_pkg::MODE_DYNAMIC_PHASE_ALIGN:
      begin
        src_bit = fifo_bit;
        bit_ok = running & fifo_ok;
      end
      srx_pkg::MODE_SOFT_CDR:
      begin
        src_bit = phase_taps[phase];
        bit_ok = running & locked;
      end
    endcase
  end

  // slip control rising edge and rollover
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      slip_prev <= 1'b0;
      slip_cnt <= 4'h0;
      slip_max <= 1'b0;
    end
    else
    begin
      slip_prev <= slip_ctl;
      slip_max <= 1'b0;
      if (!running)
        slip_cnt <= 4'h0;
      else if (slip_ctl && !slip_prev)
      begin
        if (slip_cnt + 4'h1 >= run_cfg.rollover)
        begin
          slip_cnt <= 4'h0;
          slip_max <= 1'b1;
        end
        else
          slip_cnt <= slip_cnt + 4'h1;
      end
    end
  end

  // delay line for bit insertion
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hist <= 11'h000;
    else if (bit_ok)
      hist <= {hist[9:0], src_bit};
  end

  assign slip_bit = (slip_cnt == 4'h0) ? src_bit : hist[slip_cnt - 4'h1];
  assign next_shreg = {shreg[8:0], slip_bit};
  assign word_ok = running & (mode == srx_pkg::MODE_STATIC_PHASE | locked);

  // deserializer and parallel output
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      shreg <= 10'h000;
      bit_cnt <= 4'h0;
      rx_out <= '0;
    end
    else if (bypass_on && running)
    begin
      bit_cnt <= 4'h0;
      rx_out.valid <= 1'b1;
      if (run_cfg.ddr)
        rx_out.data <= {8'h00, phase_taps[static_idx + srx_pkg::PHASE_HALF],
          phase_taps[static_idx]};
      else
        rx_out.data <= {9'h000, phase_taps[static_idx]};
    end
    else if (!bit_ok)
    begin
      rx_out.valid <= 1'b0;
      if (!running)
      begin
        shreg <= 10'h000;
        bit_cnt <= 4'h0;
      end
    end
    else
    begin
      shreg <= next_shreg;
      rx_out.valid <= 1'b0;
      if (bit_cnt == eff_factor - 4'h1)
      begin
        bit_cnt <= 4'h0;
        rx_out.data <= next_shreg & word_mask;
        rx_out.valid <= word_ok;
      end
      else
        bit_cnt <= bit_cnt + 4'h1;
    end
  end

  // recovered parallel clock, follows the word counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      par_clk_rec <= 1'b0;
    else
      par_clk_rec <= (mode == srx_pkg::MODE_SOFT_CDR) & bit_ok
        & (bit_cnt < (eff_factor >> 1));
  end

  // pll parallel clock, free divider while running
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pll_cnt <= 4'h0;
      par_clk_pll <= 1'b0;
    end
    else if (!running)
    begin
      pll_cnt <= 4'h0;
      par_clk_pll <= 1'b0;
    end
    else
    begin
      if (pll_cnt == eff_factor - 4'h1)
        pll_cnt <= 4'h0;
      else
        pll_cnt <= pll_cnt + 4'h1;
      par_clk_pll <= pll_cnt < (eff_factor >> 1);
    end
  end

  // apb slave, zero wait states
  assign setup = psel & ~penable;
  assign wr_access = psel & penable & pwrite;
  assign pready = psel & penable;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= srx_pkg::srx_ctrl_type'(srx_pkg::CTRL_RST);
      slip_ctl <= 1'b0;
    end
    else if (wr_access)
    begin
      if (paddr == srx_pkg::ADDR_CTRL)
        ctrl <= srx_pkg::srx_ctrl_type'(pwdata[srx_pkg::CTRL_W - 1:0]);
      if (paddr == srx_pkg::ADDR_SLIP)
        slip_ctl <= pwdata[0];
    end
  end

  // read data and error captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      unique case (paddr)
        srx_pkg::ADDR_CTRL:
          prdata <= {13'h0000, ctrl};
        srx_pkg::ADDR_STAT:
          prdata <= {19'h00000, fifo_ok, locked, running, slip_cnt,
            phase, mode};
        srx_pkg::ADDR_SLIP:
          prdata <= {31'h0000_0000, slip_ctl};
        srx_pkg::ADDR_WORD:
          prdata <= {21'h000000, rx_out};
        default:
          pslverr <= 1'b1;
      endcase
    end
  end
endmodule : srx_rx_datapath

// file: testbench/srx_rx_checker.sv
// port assertions for the serial receive datapath
`timescale 1ns/10ps
module srx_rx_checker
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire srx_pkg::srx_word_type rx_out,
  input wire logic pll_ref_local,
  input wire logic par_clk_rec,
  input wire logic slip_max
);
  srx_pkg::srx_ctrl_type sh;
  logic [2:0] cdr_h;
  logic [8:0] run_n;
  logic [3:0] fac;
  logic cdr;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      sh <= srx_pkg::CTRL_RST;
    else if (psel && penable && pwrite && paddr == srx_pkg::ADDR_CTRL)
      sh <= pwdata[18:0];
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      cdr_h <= 3'h0;
    else
      cdr_h <= {cdr_h[1:0], sh.mode == 3'b100};
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      run_n <= 9'h0;
    else if (!sh.enable)
      run_n <= 9'h0;
    else if (run_n != 9'h1FF)
      run_n <= run_n + 9'h1;
  assign cdr = (sh.mode == 3'b100) || (cdr_h != 3'h0);
  assign fac = (sh.factor inside {4'h4, 4'h6, 4'h7, 4'h8}) ? sh.factor : 4'hA;
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  AST_REF_LOCAL: assert property (pll_ref_local |-> cdr)
    else $error("local reference outside soft recovery");
  AST_REC_CLK: assert property (par_clk_rec |-> cdr)
    else $error("recovered clock outside soft recovery");
  AST_BYP_SDR: assert property (rx_out.valid && sh.enable && sh.bypass
    && !sh.ddr |-> rx_out.data[9:1] == 9'h0)
    else $error("single rate bypass wider than one bit");
  AST_BYP_DDR: assert property (rx_out.valid && sh.enable && sh.bypass
    && sh.ddr |-> rx_out.data[9:2] == 8'h0)
    else $error("double rate bypass wider than two bits");
  AST_WORD_FIT: assert property (rx_out.valid && sh.enable && !sh.bypass
    |-> (rx_out.data >> fac) == 10'h0)
    else $error("word wider than factor");
  AST_WORD_GAP: assert property (rx_out.valid && sh.enable && !sh.bypass
    |=> !rx_out.valid [*3])
    else $error("words closer than factor");
  AST_SLIP_PULSE: assert property (slip_max |=> !slip_max)
    else $error("rollover flag longer than one cycle");
  AST_LOCK_FIRST: assert property (rx_out.valid && sh.enable
    && sh.mode inside {3'b010, 3'b100} |-> run_n >= srx_pkg::LOCK_COUNT)
    else $error("word before lock");
  AST_IDLE_OFF: assert property (!sh.enable && !$past(sh.enable)
    && !$past(sh.enable, 2) && !$past(sh.enable, 3)
    |-> !rx_out.valid && !par_clk_rec)
    else $error("output while disabled");
endmodule : srx_rx_checker

bind srx_rx_datapath srx_rx_checker u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .rx_out(rx_out), .pll_ref_local(pll_ref_local),
  .par_clk_rec(par_clk_rec), .slip_max(slip_max));

// file: testbench/srx_tx_model.sv
// far-side transmitter: serial bits seen at eight sampling phases
`timescale 1ns/10ps
module srx_tx_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tx_bit,
  input wire logic [2:0] tx_pos,
  output logic [7:0] phase_taps
);
  logic cur_bit, prev_bit;
  // one bit each period, bit timing stands for the reference
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cur_bit <= 1'b0;
      prev_bit <= 1'b1;
    end
    else
    begin
      prev_bit <= cur_bit;
      cur_bit <= tx_bit;
    end
  // phases before the bit edge still see the old bit
  always_comb
    for (int i = 0; i < 8; i++)
      phase_taps[i] = (i < int'(tx_pos)) ? prev_bit : cur_bit;
endmodule : srx_tx_model

// file: testbench/test_srx_rx_datapath.sv
// bench for the serial receive datapath
`timescale 1ns/10ps
module test_srx_rx_datapath;
  logic pclk, presetn, psel, penable, pwrite, tx_bit, tx_rand, err;
  logic pready, pslverr, pll_ref_local, par_clk_pll, par_clk_rec, slip_max;
  logic rec_d, pll_d;
  logic [7:0] paddr, phase_taps;
  logic [31:0] pwdata, prdata, rd, r, rp;
  logic [2:0] tx_pos;
  srx_pkg::srx_word_type rx_out;
  srx_pkg::srx_ctrl_type c;
  int mismatches, checks, seed, slips, rec_n, pll_n;
  int slip_base, rec_base, pll_base;
  logic [9:0] exp_q[$];
  logic [3:0] fac_t[8] = '{4'h4, 4'h6, 4'h7, 4'h8, 4'hA, 4'h5, 4'hA, 4'hA};
  logic [9:0] exp_t[8] = '{10'hF, 10'h3F, 10'h7F, 10'hFF, 10'h3FF, 10'h3FF,
    10'h1, 10'h3};
  srx_rx_datapath DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .phase_taps(phase_taps), .pll_ref_local(pll_ref_local), .rx_out(rx_out),
    .par_clk_pll(par_clk_pll), .par_clk_rec(par_clk_rec),
    .slip_max(slip_max));
  srx_tx_model u_tx (.pclk(pclk), .presetn(presetn), .tx_bit(tx_bit),
    .tx_pos(tx_pos), .phase_taps(phase_taps));
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    r = $random(seed);
    tx_bit <= tx_rand ? r[0] : 1'b1;
  end
  // words taken one per valid pulse in the parallel domain
  always @(negedge pclk)
  begin
    if (rx_out.valid === 1'b1 && exp_q.size() > 0)
      chk_word(exp_q.pop_front(), rx_out.data);
    slips += (slip_max === 1'b1);
    rec_n += (par_clk_rec === 1'b1 && rec_d === 1'b0);
    pll_n += (par_clk_pll === 1'b1 && pll_d === 1'b0);
    rec_d = par_clk_rec;
    pll_d = par_clk_pll;
  end
  task automatic end_sim;
    if (mismatches == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  task automatic chk_reg(input string n, input logic [31:0] e, g);
    checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk_reg
  task automatic chk_word(input logic [9:0] e, g);
    checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] word exp %h got %h", e, g);
    end
  endtask : chk_word
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge pclk);
    end
    if (n >= 20)
    begin
      mismatches++;
      end_sim;
    end
    else
    begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, e,
    input string n);
    apb(1'b0, a, 32'h0);
    chk_reg(n, e, rd & m);
  endtask : rdc
  task automatic poll(input logic [31:0] m, e, input string n);
    apb(1'b0, srx_pkg::ADDR_STAT, 32'h0);
    for (int i = 0; i < 150 && (rd & m) !== e; i++)
      apb(1'b0, srx_pkg::ADDR_STAT, 32'h0);
    chk_reg(n, e, rd & m);
  endtask : poll
  task automatic go(input logic [2:0] m, input logic [3:0] f, rl,
    input logic b, dd);
    rp = $random(seed);
    c = '0;
    c.mode = m;
    c.factor = f;
    c.rollover = rl;
    c.bypass = b;
    c.ddr = dd;
    c.phase = rp[2:0];
    c.edge_fall = rp[3];
    apb(1'b1, srx_pkg::ADDR_CTRL, {13'h0, c});
    c.enable = 1'b1;
    apb(1'b1, srx_pkg::ADDR_CTRL, {13'h0, c});
  endtask : go
  task automatic drain;
    for (int i = 0; i < 300 && exp_q.size() > 0; i++)
      @(posedge pclk);
    if (exp_q.size() > 0)
    begin
      mismatches++;
      end_sim;
    end
  endtask : drain
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    tx_rand = 1'b0;
    tx_pos = 3'h0;
    seed = 33;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdc(srx_pkg::ADDR_CTRL, 32'hFFFFFFFF, {13'h0, srx_pkg::CTRL_RST}, "ctrl");
    rdc(srx_pkg::ADDR_STAT, 32'hFFFFFFFF, 32'h1, "stat");
    apb(1'b1, 8'h10, 32'hFFFFFFFF);
    chk_reg("unmapped err", 32'h1, {31'h0, err});
    rdc(8'h10, 32'hFFFFFFFF, 32'h0, "unmapped");
    for (int k = 0; k < 8; k++)
    begin
      go(3'b001, fac_t[k], 4'hA, k >= 6, k == 7);
      repeat (30) @(posedge pclk);
      repeat (3) exp_q.push_back(exp_t[k]);
      drain;
      apb(1'b1, srx_pkg::ADDR_CTRL, 32'h0);
    end
    go(3'b001, 4'h4, 4'h4, 1'b0, 1'b0);
    slip_base = slips;
    for (int i = 0; i < 4; i++)
    begin
      if (i == 2)
        rdc(srx_pkg::ADDR_STAT, 32'h3C0, 32'h80, "slip count");
      apb(1'b1, srx_pkg::ADDR_SLIP, 32'h1);
      apb(1'b1, srx_pkg::ADDR_SLIP, 32'h0);
    end
    repeat (4) @(posedge pclk);
    chk_reg("rollover", 32'h1, slips - slip_base);
    apb(1'b1, srx_pkg::ADDR_CTRL, 32'h0);
    tx_rand <= 1'b1;
    tx_pos <= 3'h3;
    go(3'b010, 4'hA, 4'hA, 1'b0, 1'b0);
    poll(32'h800, 32'h800, "dyn lock");
    // fifo needs a few cycles after lock to reach its start level
    repeat (4) @(posedge pclk);
    rdc(srx_pkg::ADDR_STAT, 32'h1038, 32'h1038, "dyn phase");
    apb(1'b1, srx_pkg::ADDR_CTRL, 32'h0);
    tx_pos <= 3'h2;
    go(3'b100, 4'hA, 4'hA, 1'b0, 1'b0);
    poll(32'h800, 32'h800, "cdr lock");
    rdc(srx_pkg::ADDR_STAT, 32'h38, 32'h30, "cdr phase");
    chk_reg("local ref", 32'h1, {31'h0, pll_ref_local});
    tx_pos <= 3'h5;
    poll(32'h38, 32'h08, "cdr track");
    // one rising edge per ten bits on both parallel clocks
    rec_base = rec_n;
    pll_base = pll_n;
    repeat (100) @(posedge pclk);
    chk_reg("rec clk", 32'hA, rec_n - rec_base);
    chk_reg("pll clk", 32'hA, pll_n - pll_base);
    apb(1'b1, srx_pkg::ADDR_CTRL, 32'h0);
    repeat (4) @(posedge pclk);
    chk_reg("ref off", 32'h0, {31'h0, pll_ref_local});
    end_sim;
  end
endmodule : test_srx_rx_datapath
